//--- rtl/supervisor_fault_output_logic.sv
// Fault combining, open-drain outputs, alert, write lock and config store control
// ---------------------------------------------------------------
// Function
// R1: manual reset low clears history if enabled
// R2: manual reset mappable to any output
// R3: undervolt ignore low masks under faults
// R4: margin ignore low masks all over and under faults
// R5: outputs only pull low or release
// R6: output is OR of mapped sources
// R7: assert immediately, release after delay
// R8: reassertion restarts release timer
// R9: alert response transaction releases alert
// R10: history access clears alert unless persisting
// R11: lock set blocks word writes
// R12: matching key allows lock bit write
// R13: store and restore commands move config
// R14: power-up loads stored config automatically
// R15: commands ignored during EEPROM transfer
// R16: aux comparator result is mappable fault
// R17: masking applies to live status too
// R18: supply lockout pulls all outputs low
// R19: delay in ticks, polarity after OR
// ---------------------------------------------------------------
`timescale 1ns/1ps
module supervisor_fault_output_logic
	import sup_fault_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	// Analog front end
	input wire logic [NUM_CH-1:0] channel_over_fault_i,
	input wire logic [NUM_CH-1:0] channel_under_fault_i,
	input wire logic [NUM_GPI-1:0] gp_input_pin_i,
	input wire logic [NUM_GPI-1:0] aux_compare_in_i,
	input wire logic supply_lockout_i,
	// Input configuration
	input wire logic [2:0] input_one_function_sel_i,
	input wire logic [2:0] input_two_function_sel_i,
	input wire logic [NUM_GPI-1:0] manual_reset_clears_history_i,
	// Output configuration
	input wire logic [NUM_GPIO*MAP_W-1:0] output_map_i,
	input wire logic [NUM_GPIO*DELAY_W-1:0] release_delay_i,
	input wire logic [NUM_GPIO-1:0] active_high_i,
	input wire logic [NUM_GPIO-1:0] is_alert_i,
	input wire logic [NUM_GPIO-1:0] gpio_is_input_i,
	// Host command side
	input wire logic ara_done_i,
	input wire logic history_access_i,
	input wire logic word_write_i,
	input wire logic lock_write_i,
	input wire logic lock_value_i,
	input wire logic [7:0] key_value_i,
	input wire logic [7:0] stored_key_i,
	input wire logic store_cmd_i,
	input wire logic restore_cmd_i,
	input wire logic [CFG_W-1:0] write_cfg_i,
	// EEPROM side
	input wire logic [CFG_W-1:0] eeprom_cfg_i,
	input wire logic eeprom_done_i,
	// Pins
	input wire logic [NUM_GPIO-1:0] gp_open_drain_pin_i,
	output logic [NUM_GPIO-1:0] gp_open_drain_pin_o,
	output logic [NUM_GPIO-1:0] gp_open_drain_pin_oe_o,
	// Status
	output logic [15:0] status_word_o,
	output logic [15:0] history_word_o,
	output logic write_lock_o,
	output logic [CFG_W-1:0] operating_cfg_o,
	output logic eeprom_busy_o,
	output logic eeprom_write_o,
	output logic [CFG_W-1:0] eeprom_wdata_o
);
	// ---------------------------------------------------------------
	// Input functions
	// ---------------------------------------------------------------
	wire logic [2:0] fn_sel [NUM_GPI];
	assign fn_sel[0] = input_one_function_sel_i;
	assign fn_sel[1] = input_two_function_sel_i;
	logic [NUM_GPI-1:0] is_manual, is_margin, is_undervolt_ignore_n, aux_res;
	always_comb begin
		for (int i = 0; i < NUM_GPI; i++) begin
			is_manual[i] = (fn_sel[i] == FN_MANUAL) && !gp_input_pin_i[i];
			is_margin[i] = (fn_sel[i] == FN_MARGIN) && !gp_input_pin_i[i];
			is_undervolt_ignore_n[i] = (fn_sel[i] == FN_UNDERVOLT_IGNORE_N) && !gp_input_pin_i[i];
			// Comparator result given as input above reference; negative sense flips it
			aux_res[i] = ((fn_sel[i] == FN_AUX_POS) && aux_compare_in_i[i]) ||
				((fn_sel[i] == FN_AUX_NEG) && !aux_compare_in_i[i]); // R16
		end
	end
	wire logic margin_ignore_n = ~|is_margin; // R4
	wire logic undervolt_ignore_n = ~|is_undervolt_ignore_n; // R3
	wire logic [NUM_CH-1:0] over_m = channel_over_fault_i & {NUM_CH{margin_ignore_n}}; // R4
	wire logic [NUM_CH-1:0] under_m = channel_under_fault_i &
		{NUM_CH{margin_ignore_n & undervolt_ignore_n}}; // R3
	wire logic [NUM_GPIO-1:0] gpio_in = gp_open_drain_pin_i & gpio_is_input_i;
	wire logic [MAP_W-1:0] sources = {gpio_in, aux_res, is_manual, under_m, over_m}; // R2
	wire logic [15:0] status_d = {3'h0, over_m[5], under_m[5], over_m[4], under_m[4],
		over_m[3], under_m[3], over_m[2], under_m[2], over_m[1], under_m[1],
		over_m[0], under_m[0], 1'b0}; // R17
	wire logic hist_clear_mr = |(is_manual & manual_reset_clears_history_i); // R1
	// Host commands are dropped while a configuration transfer owns the store
	ee_state_t ee_q, ee_d;
	wire logic busy = (ee_q != EE_IDLE); // R15
	wire logic ara_ok = ara_done_i && !busy; // R15
	wire logic hist_host_clr = history_access_i && !busy; // R15
	// ---------------------------------------------------------------
	// Output combining and release timers
	// ---------------------------------------------------------------
	logic [NUM_GPIO-1:0] cond, act_q, alert_q;
	logic [DELAY_W-1:0] cnt_q [NUM_GPIO];
	logic [NUM_GPIO-1:0] pin_q, oe_q;
	always_comb begin
		for (int g = 0; g < NUM_GPIO; g++) begin
			cond[g] = |(sources & output_map_i[g*MAP_W +: MAP_W]); // R6
		end
	end
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			act_q <= '0;
			alert_q <= '0;
			for (int g = 0; g < NUM_GPIO; g++) cnt_q[g] <= DELAY_RST;
		end else if (clk_en_i) begin
			for (int g = 0; g < NUM_GPIO; g++) begin
				if (cond[g]) begin
					act_q[g] <= 1'b1; // R7
					cnt_q[g] <= DELAY_RST; // R8
				end else if (act_q[g]) begin
					if (cnt_q[g] >= release_delay_i[g*DELAY_W +: DELAY_W]) begin
						act_q[g] <= 1'b0; // R19
					end else begin
						cnt_q[g] <= cnt_q[g] + 16'h0001; // R7
					end
				end
				// New fault wins over a clear in the same cycle
				if (cond[g] && !act_q[g]) begin
					alert_q[g] <= 1'b1;
				end else if (ara_ok) begin
					alert_q[g] <= 1'b0; // R9
				end else if (hist_host_clr && !cond[g]) begin
					alert_q[g] <= 1'b0; // R10
				end
			end
		end
	end
	wire logic [NUM_GPIO-1:0] asserted = (is_alert_i & alert_q) | (~is_alert_i & act_q);
	wire logic [NUM_GPIO-1:0] level = asserted ~^ active_high_i; // R19
	// Released level comes from the pull-up, so only a low is ever driven
	wire logic [NUM_GPIO-1:0] drive_low = (~level & ~gpio_is_input_i) |
		{NUM_GPIO{supply_lockout_i}}; // R18
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_q <= '0;
			oe_q <= '0;
		end else if (clk_en_i) begin
			pin_q <= '0; // R5
			oe_q <= drive_low; // R5
		end
	end
	assign gp_open_drain_pin_o = pin_q;
	assign gp_open_drain_pin_oe_o = oe_q;
	// ---------------------------------------------------------------
	// History, lock and configuration store
	// ---------------------------------------------------------------
	logic [15:0] status_q, hist_q;
	logic lock_q, ewr_q;
	logic [CFG_W-1:0] cfg_q, ewd_q;
	wire logic lock_ok = lock_write_i && !busy && (!lock_q || key_value_i == stored_key_i); // R12
	wire logic word_ok = word_write_i && !busy && !lock_q; // R11
	always_comb begin
		ee_d = ee_q;
		case (ee_q)
			EE_BOOT: if (eeprom_done_i) ee_d = EE_IDLE; // R14
			EE_IDLE: begin
				if (store_cmd_i) ee_d = EE_STORE; // R13
				else if (restore_cmd_i) ee_d = EE_RESTORE; // R13
			end
			EE_STORE: if (eeprom_done_i) ee_d = EE_IDLE;
			EE_RESTORE: if (eeprom_done_i) ee_d = EE_IDLE;
			default: ee_d = EE_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ee_q <= EE_BOOT; // R14
			cfg_q <= CFG_RST;
			ewr_q <= 1'b0;
			ewd_q <= CFG_RST;
			lock_q <= 1'b0;
			status_q <= HIST_RST;
			hist_q <= HIST_RST;
		end else if (clk_en_i) begin
			ee_q <= ee_d;
			ewr_q <= (ee_q == EE_IDLE) && (ee_d == EE_STORE);
			if ((ee_q == EE_IDLE) && (ee_d == EE_STORE)) ewd_q <= cfg_q; // R13
			if ((ee_q == EE_BOOT || ee_q == EE_RESTORE) && eeprom_done_i) begin
				cfg_q <= eeprom_cfg_i; // R14
			end else if (word_ok) begin
				cfg_q <= write_cfg_i; // R11
			end
			if (lock_ok) lock_q <= lock_value_i; // R12
			status_q <= status_d;
			// New faults win over a clear in the same cycle
			if (hist_clear_mr || hist_host_clr) hist_q <= status_d; // R1
			else hist_q <= hist_q | status_d;
		end
	end
	assign status_word_o = status_q;
	assign history_word_o = hist_q;
	assign write_lock_o = lock_q;
	assign operating_cfg_o = cfg_q;
	assign eeprom_busy_o = busy;
	assign eeprom_write_o = ewr_q;
	assign eeprom_wdata_o = ewd_q;
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	a_lockout_pulls_low: assert property (clk_en_i && supply_lockout_i |=> &oe_q) // R18
		else $error("lockout did not pull outputs low");
	a_open_drain_data: assert property (pin_q == '0) // R5
		else $error("open drain drove high");
	a_assert_immediate: assert property (clk_en_i && cond[0] |=> act_q[0]) // R7
		else $error("output did not assert");
	a_timer_restart: assert property (clk_en_i && cond[1] |=> cnt_q[1] == '0) // R8
		else $error("release timer not restarted");
	a_locked_no_write: assert property (clk_en_i && lock_q && !($past(ee_q) != EE_IDLE)
		&& ee_q == EE_IDLE |=> $stable(cfg_q) || $past(eeprom_done_i)) // R11
		else $error("write accepted while locked");
	a_key_unlocks: assert property (clk_en_i && lock_write_i && !busy &&
		key_value_i == stored_key_i |=> lock_q == $past(lock_value_i)) // R12
		else $error("key did not open lock");
	a_busy_ignores: assert property (clk_en_i && busy && !eeprom_done_i |=> $stable(cfg_q)) // R15
		else $error("command taken while busy");
	a_margin_masks: assert property (clk_en_i && !margin_ignore_n |=> status_q == '0) // R4
		else $error("margin did not mask");
	a_ara_clears: assert property (clk_en_i && ara_done_i && !(cond[2] && !act_q[2])
		|=> !alert_q[2]) // R9
		else $error("alert not released");
	a_manual_maps: assert property (clk_en_i && is_manual[0] && output_map_i[MAP_GPI_LSB]
		|=> act_q[0]) // R2
		else $error("manual reset not routed");
	a_under_feeds: assert property (clk_en_i && under_m[0] && output_map_i[MAP_W+MAP_UNDER_LSB]
		|=> act_q[1]) // R6
		else $error("mapped fault not combined");
	a_release_timer: assert property (clk_en_i && !cond[0] && act_q[0] &&
		cnt_q[0] < release_delay_i[DELAY_W-1:0] |=> act_q[0]) // R7
		else $error("output released early");
	a_polarity_sel: assert property (clk_en_i && !supply_lockout_i && !gpio_is_input_i[0]
		|=> oe_q[0] != $past(level[0])) // R19
		else $error("output polarity wrong");
	a_gpio_released: assert property (clk_en_i && gpio_is_input_i[0] && !supply_lockout_i
		|=> !oe_q[0]) // R5
		else $error("input pin was driven");
	a_aux_negative: assert property (clk_en_i && fn_sel[0] == FN_AUX_NEG &&
		!aux_compare_in_i[0] && output_map_i[MAP_AUX_LSB] |=> act_q[0]) // R16
		else $error("aux result not mapped");
	a_undervolt_ignore_n_masks: assert property (clk_en_i && !undervolt_ignore_n
		|=> (status_q & 16'h0aaa) == '0) // R3
		else $error("undervolt ignore did not mask");
	a_history_mr_clear: assert property (clk_en_i && hist_clear_mr && status_d == '0
		|=> hist_q == '0) // R1
		else $error("manual reset kept history");

	// ---------------------------------------------------------------
	// Checks: alert, lock and store
	// ---------------------------------------------------------------
	a_alert_raise: assert property (clk_en_i && cond[2] && !act_q[2]
		|=> alert_q[2]) // R9
		else $error("alert not raised");
	a_history_clears_alert: assert property (clk_en_i && hist_host_clr && !cond[2]
		|=> !alert_q[2]) // R10
		else $error("history access kept alert");
	a_busy_no_ara: assert property (clk_en_i && busy && ara_done_i && alert_q[2]
		|=> alert_q[2]) // R15
		else $error("alert response taken while busy");
	a_word_write: assert property (clk_en_i && word_ok
		|=> cfg_q == $past(write_cfg_i)) // R11
		else $error("open write not taken");
	a_lock_refused: assert property (clk_en_i && lock_write_i && lock_q &&
		key_value_i != stored_key_i |=> lock_q) // R12
		else $error("lock opened without key");
	a_busy_no_lock: assert property (clk_en_i && busy && lock_write_i
		|=> $stable(lock_q)) // R15
		else $error("lock write taken while busy");
	a_store_pulse: assert property (clk_en_i && ee_q == EE_IDLE && store_cmd_i
		|=> ewr_q && ewd_q == $past(cfg_q)) // R13
		else $error("store did not start");
	a_restore_load: assert property (clk_en_i && ee_q == EE_RESTORE && eeprom_done_i
		|=> cfg_q == $past(eeprom_cfg_i)) // R13
		else $error("restore did not load");
	a_boot_load: assert property (clk_en_i && ee_q == EE_BOOT && eeprom_done_i
		|=> cfg_q == $past(eeprom_cfg_i) && ee_q == EE_IDLE) // R14
		else $error("power-up load missed");

	// Main scenarios
	c_release_done: cover property (act_q[0] ##1 !act_q[0]);
	c_store_run: cover property (ee_q == EE_STORE ##1 ee_q == EE_IDLE);
	c_alert_set: cover property (!alert_q[2] ##1 alert_q[2]);
	c_restore_run: cover property (ee_q == EE_RESTORE ##1 ee_q == EE_IDLE);
	c_margin_on: cover property (margin_ignore_n ##1 !margin_ignore_n);
endmodule // supervisor_fault_output_logic

//--- rtl/sup_fault_pkg.sv
// Constants and types shared by the supervisor fault output logic
package sup_fault_pkg;
	localparam int NUM_CH = 6;
	localparam int NUM_GPI = 2;
	localparam int NUM_GPIO = 3;
	localparam int DELAY_W = 16;
	// Map vector layout: 6 over, 6 under, 2 gp inputs, 2 aux results, 3 gpio inputs
	localparam int MAP_W = 19;
	localparam int MAP_OVER_LSB = 0;
	localparam int MAP_UNDER_LSB = 6;
	localparam int MAP_GPI_LSB = 12;
	localparam int MAP_AUX_LSB = 14;
	localparam int MAP_GPIO_LSB = 16;
	localparam int CFG_W = 64;
	localparam logic [CFG_W-1:0] CFG_RST = 64'h0;
	localparam logic [15:0] HIST_RST = 16'h0000;
	localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
	// Input function codes
	localparam logic [2:0] FN_MANUAL = 3'h1;
	localparam logic [2:0] FN_MARGIN = 3'h2;
	localparam logic [2:0] FN_UNDERVOLT_IGNORE_N = 3'h3;
	localparam logic [2:0] FN_AUX_POS = 3'h4;
	localparam logic [2:0] FN_AUX_NEG = 3'h5;
	typedef enum logic [3:0] {
		EE_BOOT = 4'h1,
		EE_IDLE = 4'h2,
		EE_STORE = 4'h4,
		EE_RESTORE = 4'h8
	} ee_state_t;
endpackage

//--- sim/sup_host_model.sv
// Far-side model: configuration EEPROM and pulled-up open-drain pins
`timescale 1ns/1ps
module sup_host_model
	import sup_fault_pkg::*;
(
	// Device side
	input wire logic ref_clk_i,
	input wire logic eeprom_busy_i,
	input wire logic eeprom_write_i,
	input wire logic [CFG_W-1:0] eeprom_wdata_i,
	input wire logic [NUM_GPIO-1:0] pin_oe_i,
	// Answers
	output logic [CFG_W-1:0] eeprom_cfg_o,
	output logic eeprom_done_o,
	output logic [NUM_GPIO-1:0] pin_level_o
);
	int wait_q;
	// Nothing but the pull-up holds a released pin
	assign pin_level_o = ~pin_oe_i;
	initial begin
		eeprom_cfg_o = 64'h0123_4567_89ab_cdef;
		eeprom_done_o = 1'b0;
		wait_q = 0;
	end
	// Slow transfer so the bench can act while busy is up
	always @(posedge ref_clk_i) begin
		if (eeprom_write_i) eeprom_cfg_o <= eeprom_wdata_i;
		eeprom_done_o <= 1'b0;
		if (eeprom_busy_i && !eeprom_done_o) begin
			wait_q <= wait_q + 1;
			if (wait_q == 6) begin
				eeprom_done_o <= 1'b1;
				wait_q <= 0;
			end
		end
	end
endmodule // sup_host_model

//--- sim/tb.sv
// Self-checking bench for the supervisor fault output logic
`timescale 1ns/1ps
module tb;
	import sup_fault_pkg::*;
	logic ref_clk, resetn, lockout, ara, hacc, wwr, lwr, lval, store, restore, lock, busy, edone, ewr;
	logic [5:0] over_f, under_f;
	logic [1:0] gpi, aux;
	logic [2:0] fn1, fn2, oe, pin, pout, alrt, hi;
	logic [3:0] watch;
	logic [7:0] key;
	logic [15:0] status, hist;
	logic [56:0] map;
	logic [47:0] dly;
	logic [CFG_W-1:0] wcfg, ecfg, op_cfg, ewdata;
	int miscompares, check_count, n;
	assign watch = {busy, oe};
	supervisor_fault_output_logic supervisor_fault_output_logic_inst (
		.ref_clk_i(ref_clk), .resetn_i(resetn), .clk_en_i(1'b1),
		.channel_over_fault_i(over_f), .channel_under_fault_i(under_f),
		.gp_input_pin_i(gpi), .aux_compare_in_i(aux), .supply_lockout_i(lockout),
		.input_one_function_sel_i(fn1), .input_two_function_sel_i(fn2),
		.manual_reset_clears_history_i(2'b01), .output_map_i(map), .release_delay_i(dly),
		.active_high_i(hi), .is_alert_i(alrt), .gpio_is_input_i(3'b000),
		.ara_done_i(ara), .history_access_i(hacc), .word_write_i(wwr), .lock_write_i(lwr),
		.lock_value_i(lval), .key_value_i(key), .stored_key_i(8'h5a), .store_cmd_i(store),
		.restore_cmd_i(restore), .write_cfg_i(wcfg), .eeprom_cfg_i(ecfg), .eeprom_done_i(edone),
		.gp_open_drain_pin_i(pin), .gp_open_drain_pin_o(pout), .gp_open_drain_pin_oe_o(oe),
		.status_word_o(status), .history_word_o(hist), .write_lock_o(lock),
		.operating_cfg_o(op_cfg), .eeprom_busy_o(busy), .eeprom_write_o(ewr),
		.eeprom_wdata_o(ewdata));
	sup_host_model sup_host_model_inst (.ref_clk_i(ref_clk), .eeprom_busy_i(busy),
		.eeprom_write_i(ewr), .eeprom_wdata_i(ewdata), .pin_oe_i(oe), .eeprom_cfg_o(ecfg),
		.eeprom_done_o(edone), .pin_level_o(pin));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#2;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait; n gives the cycles spent
	task automatic wait_for(input int g, input logic v);
		n = 0;
		while (watch[g] !== v) begin
			tick(1);
			n++;
			if (n > 60) begin
				miscompares++;
				complete_run();
			end
		end
	endtask
	// Order: ara, history, word write, lock write, store, restore
	task automatic strobe(input logic [5:0] s);
		{ara, hacc, wwr, lwr, store, restore} = s;
		tick(1);
		{ara, hacc, wwr, lwr, store, restore} = 6'h00;
		tick(1);
	endtask
	task automatic lock_wr(input logic v, input logic [7:0] k, input logic exp);
		lval = v;
		key = k;
		strobe(6'h04);
		check(lock, exp);
	endtask
	initial begin
		{resetn, lockout, ara, hacc, wwr, lwr, lval, store, restore} = '0;
		{over_f, under_f, aux, fn1, fn2, key, wcfg} = '0;
		gpi = 2'b11;
		alrt = 3'b100;
		hi = 3'b000;
		map = {19'h00001, 19'h00040, 19'h05001};
		dly = {16'h0000, 16'h0000, 16'h0005};
		tick(16);
		resetn = 1'b1;
		wait_for(3, 1'b0);
		check(op_cfg, 64'h0123_4567_89ab_cdef);
		// Fault, release delay, alert and retrigger
		over_f = 6'h01;
		wait_for(0, 1'b1);
		check(n <= 3, 1'b1);
		tick(1);
		check({oe, status}, {3'b101, 16'h0004});
		over_f = 6'h00;
		wait_for(0, 1'b0);
		check(n >= 5 && n <= 9, 1'b1);
		check(oe[2], 1'b1);
		strobe(6'h20);
		check(oe[2], 1'b0);
		over_f = 6'h01;
		tick(4);
		over_f = 6'h00;
		tick(3);
		over_f = 6'h01;
		tick(1);
		over_f = 6'h00;
		wait_for(0, 1'b0);
		check(n >= 5, 1'b1);
		strobe(6'h10);
		check(oe[2], 1'b0);
		// Manual reset, margin and undervolt ignore
		fn1 = FN_MANUAL;
		gpi = 2'b10;
		tick(3);
		check({oe[0], hist}, 17'h10000);
		fn1 = FN_MARGIN;
		{over_f, under_f} = 12'h041;
		tick(8);
		check({oe, status}, 19'h0);
		{fn1, fn2, gpi} = {3'h0, FN_UNDERVOLT_IGNORE_N, 2'b01};
		tick(4);
		check({oe[1], status}, 17'h00004);
		gpi = 2'b11;
		{over_f, under_f, fn2} = '0;
		wait_for(0, 1'b0);
		strobe(6'h20);
		// Aux comparator, both connections
		fn1 = FN_AUX_POS;
		aux = 2'b01;
		tick(3);
		check(oe[0], 1'b1);
		fn1 = FN_AUX_NEG;
		aux = 2'b00;
		tick(20);
		check(oe[0], 1'b1);
		aux = 2'b01;
		wait_for(0, 1'b0);
		fn1 = 3'h0;
		lockout = 1'b1;
		tick(3);
		check(oe, 3'b111);
		check(pout, 3'b000);
		lockout = 1'b0;
		hi = 3'b010;
		tick(3);
		check(oe[1], 1'b1);
		hi = 3'b000;
		// Write lock and key
		wcfg = 64'h1;
		strobe(6'h08);
		lock_wr(1'b1, 8'h00, 1'b1);
		wcfg = 64'h2;
		strobe(6'h08);
		check(op_cfg, 64'h1);
		lock_wr(1'b0, 8'h00, 1'b1);
		lock_wr(1'b0, 8'h5a, 1'b0);
		// Store, ignored write while busy, restore
		store = 1'b1;
		tick(1);
		store = 1'b0;
		strobe(6'h08);
		check(busy, 1'b1);
		wait_for(3, 1'b0);
		check(op_cfg, 64'h1);
		strobe(6'h08);
		check(op_cfg, 64'h2);
		restore = 1'b1;
		tick(1);
		restore = 1'b0;
		wait_for(3, 1'b0);
		tick(1);
		check(op_cfg, 64'h1);
		complete_run();
	end
endmodule // tb
